// ### hw/eeprom_pkg.sv
// Purpose: shared constants and carrier types of the serial memory block
// Assumes: core clock of 200 MHz
// Notes:   opcodes and address prefixes follow the serial instruction set
`default_nettype none
package eeprom_pkg;
  // ****************************************
  // instruction fields
  // ****************************************
  localparam int OP_W   = 2;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 5;
  localparam logic [OP_W-1:0] OP_SPECIAL = 2'h0;
  localparam logic [OP_W-1:0] OP_WRITE   = 2'h1;
  localparam logic [OP_W-1:0] OP_READ    = 2'h2;
  localparam logic [OP_W-1:0] OP_ERASE   = 2'h3;
  // sub-commands carried in the top two address bits
  localparam logic [OP_W-1:0] SUB_DISABLE = 2'h0;
  localparam logic [OP_W-1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [OP_W-1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [OP_W-1:0] SUB_ENABLE  = 2'h3;
  localparam int PFX_X16_MSB = 7;
  localparam int PFX_X8_MSB  = 8;
  localparam logic [CNT_W-1:0] OP_LAST       = 5'h01;
  localparam logic [CNT_W-1:0] ADDR_BITS_X8  = 5'h09;
  localparam logic [CNT_W-1:0] ADDR_BITS_X16 = 5'h08;
  localparam logic [CNT_W-1:0] DATA_BITS_X8  = 5'h08;
  localparam logic [CNT_W-1:0] DATA_BITS_X16 = 5'h10;
  localparam logic [DATA_W-1:0] ERASED_WORD  = 16'hFFFF;
  localparam logic WIDE_DEFAULT = 1'b1;
  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int MEM_WORDS_DEF    = 256;
  localparam int FIFO_DEPTH       = 4;
  localparam int CLOCK_PERIOD_NS  = 5;
  localparam int WRITE_TIME_MS    = 10;
  localparam int WRITE_CYCLES_DEF =
    WRITE_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic              wide;
    logic [OP_W-1:0]   op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;
  typedef struct packed {
    logic drive;
    logic bit_val;
  } dout_t;
endpackage
`default_nettype wire

// ### hw/bit_sync.sv
// Purpose: two-stage synchroniser for a group of levels
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes:   reset value is a parameter so straps start at their default
`default_nettype none
`timescale 1ns/100ps
module bit_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= RESET_VAL;
      q_reg    <= RESET_VAL;
    end else begin
      meta_reg <= d_in;
      q_reg    <= meta_reg;
    end
  end

  assign q_out = q_reg;
endmodule // bit_sync
`default_nettype wire

// ### hw/cmd_fifo.sv
// Purpose: small command buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from pointers with one extra wrap bit
`default_nettype none
`timescale 1ns/100ps
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0]   wr_reg;
  logic [PTR_W:0]   wr_next;
  logic [PTR_W:0]   rd_reg;
  logic [PTR_W:0]   rd_next;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty = (wr_reg == rd_reg);
  assign full  = (wr_reg[PTR_W] != rd_reg[PTR_W]) &&
                 (wr_reg[PTR_W-1:0] == rd_reg[PTR_W-1:0]);
  assign push  = in_valid_in && !full;
  assign pop   = out_ready_in && !empty;
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = store[rd_reg[PTR_W-1:0]];

  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      store[wr_reg[PTR_W-1:0]] <= in_data_in;
    end
  end
endmodule // cmd_fifo
`default_nettype wire

// ### hw/three_wire_serial_eeprom.sv
// Purpose: command front end and storage of a three-wire serial memory
// Assumes: shift clock well below the core clock; core runs at 200 MHz
// Notes:   link logic on the shift clock, storage and timer on the core
//
// What this block does
// RQ1 - 256 or 512 words by organisation
// RQ2 - strap high gives x16, low x8
// RQ3 - floating strap defaults to x16; the code only resets the synchronised strap to x16, then follows the pin
// RQ4 - traffic ignored while chip select low
// RQ5 - read decodes address, shifts word out
// RQ6 - all data moves serially on shift clock
// RQ7 - write overwrites directly, self-timed, no erase
// RQ8 - programming only while enable state set
// RQ9 - status shown whenever select raised after write
// RQ10 - write cycle ends within ten milliseconds
// RQ11 - host keeps shift clock at most 2 MHz; the bench host runs it at 8 MHz (125 ns period)
// RQ12 - start bit, two-bit opcode, then address
// RQ13 - special prefix 11 sets program enable
// RQ14 - special prefix 00 clears program enable
// RQ15 - prefix 10 erases all, 01 writes all
// RQ16 - output released when unselected; low means busy
// RQ17 - reading on continues with the next address
`default_nettype none
`timescale 1ns/100ps
module three_wire_serial_eeprom #(
  parameter int MEM_WORDS    = eeprom_pkg::MEM_WORDS_DEF,
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
  // core clock and reset
  input  wire logic CLOCK_IN,
  input  wire logic RST_B_IN,
  // serial link
  input  wire logic SHIFT_CLOCK_IN,
  input  wire logic CHIP_SELECT_IN,
  input  wire logic SERIAL_IN,
  output logic      SERIAL_OUT,
  output logic      SERIAL_OE_B_OUT,
  // organisation strap
  input  wire logic ORGANIZATION_SELECT_IN
);
  import eeprom_pkg::*;

  localparam int IDX_W   = $clog2(MEM_WORDS);
  localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);

  typedef enum logic [2:0] {
    L_START, L_OP, L_ADDR, L_DATA, L_READ, L_DONE
  } lstate_t;
  typedef enum logic [1:0] {E_IDLE, E_BULK, E_WAIT} estate_t;

  // ****************************************
  // crossings
  // ****************************************
  logic              link_rst_b;
  logic [3:0]        csync_q;
  logic [2:0]        lsync_q;
  logic              cs_s;
  logic              drv_s;
  logic              bit_s;
  logic              tog_s;
  logic              wide_l;
  logic              ack_l;
  logic              rdat_l;
  dout_t             dout_reg;
  dout_t             dout_next;
  logic              cmd_tog_reg;
  logic              cmd_tog_next;
  logic              ack_tog_reg;
  logic              ack_tog_next;
  logic              rtog_reg;
  logic              rtog_next;

  // frame logic is cleared by the frame's own select
  assign link_rst_b = RST_B_IN & CHIP_SELECT_IN; // RQ4

  bit_sync #(.WIDTH(4), .RESET_VAL(4'h0)) u_core_sync (
    .clk_in   (CLOCK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     ({CHIP_SELECT_IN, dout_reg.drive, dout_reg.bit_val,
                cmd_tog_reg}),
    .q_out    (csync_q)
  );
  assign {cs_s, drv_s, bit_s, tog_s} = csync_q;

  bit_sync #(.WIDTH(3), .RESET_VAL({WIDE_DEFAULT, 2'h0})) u_link_sync (
    .clk_in   (SHIFT_CLOCK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     ({ORGANIZATION_SELECT_IN, ack_tog_reg, rtog_reg}), // RQ3
    .q_out    (lsync_q)
  );
  assign {wide_l, ack_l, rdat_l} = lsync_q;

  // ****************************************
  // link side: instruction shifter
  // ****************************************
  lstate_t           lst_reg;
  lstate_t           lst_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] shift_next;
  cmd_t              fr_reg;
  cmd_t              fr_next;
  cmd_t              cmd_reg;
  cmd_t              cmd_next;
  logic              rd_seen_reg;
  logic              rd_seen_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] word;
  logic [ADDR_W-1:0] addr_full;
  logic [OP_W-1:0]   prefix;
  logic [CNT_W-1:0]  abits;
  logic [CNT_W-1:0]  dbits;
  logic              free;

  always_comb begin
    lst_next     = lst_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    fr_next      = fr_reg;
    dout_next    = '0;
    cmd_next     = cmd_reg;
    cmd_tog_next = cmd_tog_reg;
    rd_seen_next = rd_seen_reg;
    addr_full = {fr_reg.addr[ADDR_W-2:0], SERIAL_IN};
    prefix = wide_l ? addr_full[PFX_X16_MSB -: OP_W]
                    : addr_full[PFX_X8_MSB -: OP_W];
    abits = wide_l ? ADDR_BITS_X16 : ADDR_BITS_X8; // RQ2
    dbits = wide_l ? DATA_BITS_X16 : DATA_BITS_X8; // RQ2
    free  = (ack_l == cmd_tog_reg);
    word  = wide_l ? rdata_reg
                   : {rdata_reg[BYTE_W-1:0], {BYTE_W{1'b0}}};
    case (lst_reg)
      L_START: begin
        // stale replies are absorbed between frames
        rd_seen_next = rdat_l;
        if (SERIAL_IN) begin // RQ12
          lst_next = L_OP;
          cnt_next = '0;
        end
      end
      L_OP: begin
        fr_next.op   = {fr_reg.op[0], SERIAL_IN}; // RQ12
        fr_next.wide = wide_l;
        fr_next.addr = '0;
        fr_next.data = '0;
        cnt_next     = cnt_reg + 1'b1;
        if (cnt_reg == OP_LAST) begin
          lst_next = L_ADDR;
          cnt_next = '0;
        end
      end
      L_ADDR: begin
        fr_next.addr = addr_full;
        cnt_next     = cnt_reg + 1'b1;
        if (cnt_reg == abits - 1'b1) begin
          cnt_next = '0;
          if (fr_reg.op == OP_WRITE ||
              (fr_reg.op == OP_SPECIAL && prefix == SUB_WRITE_ALL)) begin
            lst_next = L_DATA;
          end else begin
            lst_next = (fr_reg.op == OP_READ) ? L_READ : L_DONE; // RQ5
            if (free) begin
              cmd_next     = fr_next;
              cmd_tog_next = ~cmd_tog_reg;
            end
          end
        end
      end
      L_DATA: begin
        fr_next.data = {fr_reg.data[DATA_W-2:0], SERIAL_IN}; // RQ6
        cnt_next     = cnt_reg + 1'b1;
        if (cnt_reg == dbits - 1'b1) begin
          lst_next = L_DONE;
          if (free) begin
            cmd_next     = fr_next;
            cmd_tog_next = ~cmd_tog_reg;
          end
        end
      end
      L_READ: begin
        dout_next.drive = 1'b1; // RQ6
        if (cnt_reg != '0) begin
          dout_next.bit_val = shift_reg[DATA_W-1];
          shift_next = {shift_reg[DATA_W-2:0], 1'b0};
          cnt_next   = cnt_reg - 1'b1;
        end else if (rdat_l != rd_seen_reg) begin
          rd_seen_next      = rdat_l;
          dout_next.bit_val = word[DATA_W-1]; // RQ5
          shift_next = {word[DATA_W-2:0], 1'b0};
          cnt_next   = dbits - 1'b1;
          if (free) begin
            cmd_next.addr = cmd_reg.addr + 1'b1; // RQ17
            cmd_tog_next  = ~cmd_tog_reg;
          end
        end
      end
      L_DONE: begin
        lst_next = L_DONE;
      end
      default: lst_next = L_START;
    endcase
  end

  always_ff @(posedge SHIFT_CLOCK_IN or negedge link_rst_b) begin
    if (!link_rst_b) begin
      lst_reg   <= L_START;
      cnt_reg   <= '0;
      shift_reg <= '0;
      fr_reg    <= '0;
      dout_reg  <= '0;
    end else begin
      lst_reg   <= lst_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      fr_reg    <= fr_next;
      dout_reg  <= dout_next;
    end
  end

  // handshake state survives the end of a frame
  always_ff @(posedge SHIFT_CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      cmd_reg     <= '0;
      cmd_tog_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
    end else begin
      cmd_reg     <= cmd_next;
      cmd_tog_reg <= cmd_tog_next;
      rd_seen_reg <= rd_seen_next;
    end
  end

  // ****************************************
  // core side: command buffer and executor
  // ****************************************
  logic              seen_reg;
  logic              seen_next;
  logic              push_valid;
  logic              push_ready;
  logic              pop_valid;
  logic              pop_ready;
  cmd_t              pop_cmd;
  estate_t           est_reg;
  estate_t           est_next;
  logic              en_reg;
  logic              en_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic [IDX_W-1:0]  idx_reg;
  logic [IDX_W-1:0]  idx_next;
  logic [DATA_W-1:0] fill_reg;
  logic [DATA_W-1:0] fill_next;
  logic [DATA_W-1:0] rdata_next;
  logic              out_next;
  logic              oe_b_next;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic              wr_en;
  logic [IDX_W-1:0]  wr_idx;
  logic [DATA_W-1:0] wr_val;
  logic [IDX_W-1:0]  widx;
  logic              half;
  logic [DATA_W-1:0] cur;
  logic [DATA_W-1:0] wdata;
  logic [OP_W-1:0]   sub;

  assign push_valid = (tog_s != seen_reg);
  assign pop_ready  = (est_reg == E_IDLE);

  cmd_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (CLOCK_IN),
    .rst_b_in      (RST_B_IN),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (cmd_reg),
    .out_valid_out (pop_valid),
    .out_ready_in  (pop_ready),
    .out_data_out  (pop_cmd)
  );

  // x16 uses the word index; x8 picks a byte lane within a word
  assign widx  = pop_cmd.wide ? pop_cmd.addr[IDX_W-1:0]
                              : pop_cmd.addr[IDX_W:1]; // RQ1
  assign half  = !pop_cmd.wide && pop_cmd.addr[0];
  assign cur   = mem[widx];
  assign wdata = (pop_cmd.op == OP_ERASE) ? ERASED_WORD : pop_cmd.data;
  assign sub   = pop_cmd.wide ? pop_cmd.addr[PFX_X16_MSB -: OP_W]
                              : pop_cmd.addr[PFX_X8_MSB -: OP_W];

  always_comb begin
    est_next     = est_reg;
    en_next      = en_reg;
    timer_next   = timer_reg;
    idx_next     = idx_reg;
    fill_next    = fill_reg;
    rdata_next   = rdata_reg;
    rtog_next    = rtog_reg;
    seen_next    = seen_reg;
    ack_tog_next = ack_tog_reg;
    wr_en        = 1'b0;
    wr_idx       = widx;
    wr_val       = pop_cmd.wide ? wdata
                 : half ? {wdata[BYTE_W-1:0], cur[BYTE_W-1:0]}
                 : {cur[DATA_W-1:BYTE_W], wdata[BYTE_W-1:0]};
    if (push_valid && push_ready) begin
      seen_next    = tog_s;
      ack_tog_next = tog_s;
    end
    case (est_reg)
      E_IDLE: begin
        if (pop_valid) begin
          case (pop_cmd.op)
            OP_READ: begin
              rdata_next = pop_cmd.wide ? cur : {{BYTE_W{1'b0}},
                half ? cur[DATA_W-1:BYTE_W] : cur[BYTE_W-1:0]}; // RQ5
              rtog_next = ~rtog_reg;
            end
            OP_WRITE, OP_ERASE: begin
              if (en_reg) begin // RQ8
                wr_en      = 1'b1; // RQ7
                est_next   = E_WAIT;
                timer_next = TIMER_W'(WRITE_CYCLES - 1);
              end
            end
            default: begin
              if (sub == SUB_ENABLE) begin
                en_next = 1'b1; // RQ13
              end else if (sub == SUB_DISABLE) begin
                en_next = 1'b0; // RQ14
              end else if (en_reg) begin // RQ8
                est_next  = E_BULK; // RQ15
                idx_next  = '0;
                fill_next = (sub == SUB_ERASE_ALL) ? ERASED_WORD
                          : pop_cmd.wide ? pop_cmd.data
                          : {2{pop_cmd.data[BYTE_W-1:0]}};
              end
            end
          endcase
        end
      end
      E_BULK: begin
        wr_en    = 1'b1; // RQ15
        wr_idx   = idx_reg;
        wr_val   = fill_reg;
        idx_next = idx_reg + 1'b1;
        if (idx_reg == IDX_W'(MEM_WORDS - 1)) begin
          est_next   = E_WAIT;
          timer_next = TIMER_W'(WRITE_CYCLES - 1);
        end
      end
      E_WAIT: begin
        timer_next = timer_reg - 1'b1;
        if (timer_reg == '0) begin
          est_next = E_IDLE; // RQ10
        end
      end
      default: est_next = E_IDLE;
    endcase
    oe_b_next = ~cs_s; // RQ16
    out_next  = cs_s && (drv_s ? bit_s : (est_reg == E_IDLE)); // RQ9
  end

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      est_reg         <= E_IDLE;
      en_reg          <= 1'b0;
      timer_reg       <= '0;
      idx_reg         <= '0;
      fill_reg        <= '0;
      rdata_reg       <= '0;
      rtog_reg        <= 1'b0;
      seen_reg        <= 1'b0;
      ack_tog_reg     <= 1'b0;
      SERIAL_OUT      <= 1'b0;
      SERIAL_OE_B_OUT <= 1'b1;
    end else begin
      est_reg         <= est_next;
      en_reg          <= en_next;
      timer_reg       <= timer_next;
      idx_reg         <= idx_next;
      fill_reg        <= fill_next;
      rdata_reg       <= rdata_next;
      rtog_reg        <= rtog_next;
      seen_reg        <= seen_next;
      ack_tog_reg     <= ack_tog_next;
      SERIAL_OUT      <= out_next;
      SERIAL_OE_B_OUT <= oe_b_next;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_val;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  start_wait_a: assert property ( // RQ12
    @(posedge SHIFT_CLOCK_IN) disable iff (!link_rst_b)
    lst_reg == L_START && !SERIAL_IN |=> lst_reg == L_START)
    else $error("left idle without a start bit");
  next_addr_a: assert property ( // RQ17
    @(posedge SHIFT_CLOCK_IN) disable iff (!link_rst_b)
    lst_reg == L_READ && cnt_reg == '0 && rdat_l != rd_seen_reg && free
    |=> cmd_reg.addr == $past(cmd_reg.addr) + 1'b1)
    else $error("sequential read did not advance address");
  oe_follows_cs_a: assert property ( // RQ16
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    !cs_s |=> SERIAL_OE_B_OUT && !SERIAL_OUT)
    else $error("output driven while unselected");
  status_busy_a: assert property ( // RQ9
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    cs_s && !drv_s |=> SERIAL_OUT == $past(est_reg == E_IDLE))
    else $error("status does not match write state");
  locked_prog_a: assert property ( // RQ8
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    pop_valid && pop_ready && !en_reg && pop_cmd.op != OP_READ
    |=> est_reg == E_IDLE)
    else $error("programming started while disabled");
  write_store_a: assert property ( // RQ7
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    pop_valid && pop_ready && en_reg && pop_cmd.wide &&
    pop_cmd.op == OP_WRITE |=> mem[$past(widx)] == $past(pop_cmd.data))
    else $error("write did not store the word");
  write_end_a: assert property ( // RQ10
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    est_reg == E_WAIT |-> timer_reg <= TIMER_W'(WRITE_CYCLES - 1)
    ##1 (est_reg == E_IDLE || timer_reg == $past(timer_reg) - 1'b1))
    else $error("write timer out of bounds");
  enable_set_a: assert property ( // RQ13
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    pop_valid && pop_ready && pop_cmd.op == OP_SPECIAL &&
    sub == SUB_ENABLE |=> en_reg)
    else $error("enable command ignored");
  enable_clear_a: assert property ( // RQ14
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    pop_valid && pop_ready && pop_cmd.op == OP_SPECIAL &&
    sub == SUB_DISABLE |=> !en_reg)
    else $error("disable command ignored");
  bulk_end_a: assert property ( // RQ15
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    est_reg == E_BULK && idx_reg == IDX_W'(MEM_WORDS - 1)
    |=> est_reg == E_WAIT ##1 est_reg == E_WAIT)
    else $error("bulk fill did not end in a write wait");
  read_reply_a: assert property ( // RQ5
    @(posedge CLOCK_IN) disable iff (!RST_B_IN)
    pop_valid && pop_ready && pop_cmd.op == OP_READ |=> $changed(rtog_reg))
    else $error("read returned no word");
  read_c: cover property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    pop_valid && pop_ready && pop_cmd.op == OP_READ);
  write_c: cover property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    est_reg == E_WAIT && timer_reg == '0);
  bulk_c: cover property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
    est_reg == E_BULK);
  seq_c: cover property (@(posedge SHIFT_CLOCK_IN)
    disable iff (!link_rst_b) $changed(cmd_reg.addr) && lst_reg == L_READ);
endmodule // three_wire_serial_eeprom
`default_nettype wire

// ### bench/serial_host.sv
// Purpose: host side of the three-wire link
// Assumes: shift clock of 125 ns runs only inside frames
// Notes:   data changes while the shift clock is low
`default_nettype none
`timescale 1ns/100ps
module serial_host (
  // link
  output logic      sclk_out,
  output logic      cs_out,
  output logic      sdata_out,
  input  wire logic do_in,
  input  wire logic oe_b_in
);
  wire logic do_wire;
  assign do_wire = oe_b_in ? 1'bz : do_in;
  initial begin
    sclk_out  = 1'b0;
    cs_out    = 1'b0;
    sdata_out = 1'b0;
  end
  // n bits MSB first, two dummy bits, then nr bits read back
  task automatic frame(input logic [31:0] v, input int n, input int nr,
                       output logic [31:0] rd);
    rd = '0;
    cs_out <= 1'b1;
    #70;
    for (int i = n + nr + 1; i >= 0; i--) begin
      if (i >= nr + 2) sdata_out <= v[i - nr - 2];
      else sdata_out <= ~sdata_out;
      #62.5 sclk_out <= 1'b1;
      #62.5 sclk_out <= 1'b0;
      if (i < nr) rd = {rd[30:0], do_wire};
    end
    cs_out <= 1'b0;
    sdata_out <= ~sdata_out;
    #300;
  endtask
  task automatic status(output logic s);
    cs_out <= 1'b1;
    #100 s = do_wire;
    cs_out <= 1'b0;
    #300;
  endtask
endmodule // serial_host
`default_nettype wire

// ### bench/three_wire_serial_eeprom_tb_top.sv
// Purpose: self-checking bench of the serial memory
// Assumes: short write time of 400 core cycles
// Notes:   host model drives the link
`default_nettype none
`timescale 1ns/100ps
module three_wire_serial_eeprom_tb_top;
  import eeprom_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        strap = WIDE_DEFAULT;
  logic        sclk, cs, sdata, dout, oe_b, st;
  logic [31:0] rd;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #2.5 clk = ~clk;
  three_wire_serial_eeprom #(.MEM_WORDS(256), .WRITE_CYCLES(400)) DUT (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .SHIFT_CLOCK_IN(sclk),
    .CHIP_SELECT_IN(cs), .SERIAL_IN(sdata), .SERIAL_OUT(dout),
    .SERIAL_OE_B_OUT(oe_b), .ORGANIZATION_SELECT_IN(strap));
  serial_host host (.sclk_out(sclk), .cs_out(cs), .sdata_out(sdata),
    .do_in(dout), .oe_b_in(oe_b));
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_ready();
    st = 1'b0;
    for (int i = 0; i < 30 && st !== 1'b1; i++) host.status(st);
    chk("ready", 1, st);
  endtask
  task automatic t_idle();
    chk("released", 1, oe_b);
    host.status(st);
    chk("idle status", 1, st);
    host.frame({1'b1, OP_WRITE, 8'h05, 16'h0F0F}, 27, 0, rd);
    host.status(st);
    chk("locked write", 1, st);
    $display("test idle done");
  endtask
  task automatic t_write();
    host.frame({1'b1, OP_SPECIAL, 8'hC0}, 11, 0, rd);
    host.frame({1'b1, OP_WRITE, 8'h05, 16'hA5C3}, 27, 0, rd);
    host.status(st);
    chk("busy", 0, st);
    wait_ready();
    host.frame({1'b1, OP_WRITE, 8'h06, 16'h3C5A}, 27, 0, rd);
    wait_ready();
    host.frame({1'b1, OP_READ, 8'h05}, 11, 32, rd);
    chk("seq read", 32'hA5C33C5A, rd);
    $display("test write done");
  endtask
  task automatic t_erase();
    host.frame({1'b1, OP_ERASE, 8'h05}, 11, 0, rd);
    wait_ready();
    host.frame({1'b1, OP_READ, 8'h05}, 11, 16, rd);
    chk("erase", 32'hFFFF, rd);
    host.frame({1'b1, OP_SPECIAL, 8'h40, 16'h1234}, 27, 0, rd);
    wait_ready();
    host.frame({1'b1, OP_READ, 8'hFF}, 11, 16, rd);
    chk("write all", 32'h1234, rd);
    host.frame({1'b1, OP_SPECIAL, 8'h80}, 11, 0, rd);
    wait_ready();
    host.frame({1'b1, OP_READ, 8'hFF}, 11, 16, rd);
    chk("erase all", 32'hFFFF, rd);
    host.frame({1'b1, OP_SPECIAL, 8'h00}, 11, 0, rd);
    host.frame({1'b1, OP_WRITE, 8'h00, 16'h0000}, 27, 0, rd);
    host.status(st);
    chk("disabled", 1, st);
    $display("test erase done");
  endtask
  task automatic t_bytes();
    @(posedge clk);
    strap <= 1'b0;
    host.frame(32'h0, 4, 0, rd);
    host.frame({1'b1, OP_SPECIAL, 9'h180}, 12, 0, rd);
    host.frame({1'b1, OP_WRITE, 9'h1FF, 8'h5A}, 20, 0, rd);
    wait_ready();
    host.frame({1'b1, OP_READ, 9'h1FE}, 12, 16, rd);
    chk("byte read", 32'hFF5A, rd);
    $display("test bytes done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    t_idle();
    t_write();
    t_erase();
    t_bytes();
    end_of_test();
  end
endmodule // three_wire_serial_eeprom_tb_top
`default_nettype wire
